//--- hdl/pcu_map.vh
// Register map, field positions, reset values and timing for the
// power, clock and reset register bank. Definitions only.
`ifndef PCU_MAP_VH
`define PCU_MAP_VH

// Window bases, as register indices; byte address is four times index
`define PCU_BASE_BLK       10'h200
`define PCU_BASE_NBLK      10'h300

// Register indices inside a window
`define PCU_IDX_CTL        4'h0
`define PCU_IDX_RST_STAT   4'h2
`define PCU_IDX_WAKE_STAT  4'h3
`define PCU_IDX_PRESC      4'h4
`define PCU_IDX_WUE_HI     4'h6
`define PCU_IDX_WUE_LO     4'h7
`define PCU_IDX_TRIM_HI    4'hE
`define PCU_IDX_TRIM_LO    4'hF

// Control register fields
`define PCU_CTL_OT_MASK    15
`define PCU_CTL_UV_MASK    14
`define PCU_CTL_RST_MASK   13
`define PCU_CTL_PF_MASK_HI 11
`define PCU_CTL_PF_MASK_LO 10
`define PCU_CTL_MD_MASK_HI 9
`define PCU_CTL_MD_MASK_LO 8
`define PCU_CTL_OT_IRQ     7
`define PCU_CTL_UV_IRQ     6
`define PCU_CTL_RST_CMD    5
`define PCU_CTL_PF_HI      3
`define PCU_CTL_PF_LO      2
`define PCU_CTL_MD_HI      1
`define PCU_CTL_MD_LO      0

// Operating modes
`define PCU_MODE_NORMAL    2'h0
`define PCU_MODE_STOP      2'h1
`define PCU_MODE_SLEEP     2'h2
`define PCU_MODE_CRANK     2'h3

// Reset values
`define PCU_CTL_RESET      8'h00
`define PCU_PRESC_RESET    16'h7D00
`define PCU_WUE_RESET      8'h00

// AXI responses
`define PCU_RESP_OKAY      2'h0
`define PCU_RESP_SLVERR    2'h2

// Die reset pulse on the external reset output
`define PCU_CLK_PERIOD_NS  4
`define PCU_RST_PULSE_NS   1000
`define PCU_RST_PULSE_CYC  ((`PCU_RST_PULSE_NS + `PCU_CLK_PERIOD_NS - 1) / `PCU_CLK_PERIOD_NS)

`endif

//--- hdl/pcu_regs.v
// Power, clock and reset register bank with an AXI4-Lite slave port.
// Assumes one clock (mclk); condition and event inputs come from other
// logic and pins and are synchronised here. Trim inputs are static.
`timescale 1ns/1ns
`include "pcu_map.vh"

// Function
// - Registers decode at offset plus base 0x0200 or 0x300.
// - Overtemp interrupt control changes only with mask bit 15 set.
// - Undervolt interrupt control changes only with mask bit 14 set.
// - Reset command with mask resets die logic and drives reset out.
// - Reset command is write-only, needs its mask; writing 0 does nothing.
// - Prescale factor changes only when its mask is written 11.
// - Prescale factor divides the 1 ms tick by 1, 2, 4 or 8.
// - Mode changes only when its mask is written 11.
// - Mode 00 normal, 01 stop, 10 sleep.
// - Mode 11 is cranking if enabled, otherwise stop.
// - Overtemp interrupt control is inverted: 0 enables.
// - Undervolt interrupt control is inverted: 0 enables.
// - Writing 1 to a status bit clears it; 0 leaves it.
// - Sixteen-bit read/write millisecond divider at offset 0x04.
// - Read-only trim at 0x0E/0x0F: 13-bit value plus top flag.
// - Overtemp/undervolt flags are live; writing 1 clears interrupt source.
// - Command reset flag set by command reset, held until cleared.
// - Wake flags record which enabled wake source rose, in any mode.
module pcu_regs #(
	parameter        RST_PULSE_CYC = `PCU_RST_PULSE_CYC,
	parameter [15:0] PRESC_RESET   = `PCU_PRESC_RESET
) (
	input  wire        mclk,
	input  wire        reset,
	input  wire [11:0] s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [11:0] s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        overtemp_cond,
	input  wire        undervolt_cond,
	input  wire [4:0]  reset_cause_evt,
	input  wire [7:0]  wake_evt,
	input  wire        crank_feature_en,
	input  wire        ms_tick,
	input  wire [12:0] trim_value,
	input  wire        trim_flag,
	output reg         overtemp_irq_en,
	output reg         undervolt_irq_en,
	output reg         overtemp_irq_clr,
	output reg         undervolt_irq_clr,
	output reg         die_reset_out,
	output reg  [1:0]  mode_state,
	output reg         cranking_active,
	output reg         scaled_tick,
	output reg  [15:0] ms_divider_value,
	output reg  [8:0]  wake_enable
);

	localparam ST_RUN  = 2'b01;
	localparam ST_HOLD = 2'b10;
	localparam SYNC_W  = 31;
	localparam EVT_W   = 14;

	// Returns {hit, index}; both windows map the same registers
	function [4:0] pcu_decode;
		input [11:0] addr;
		reg   [9:0]  word;
		begin
			word = addr[11:2];
			pcu_decode = 5'h00;
			if (({word[9:4], 4'h0} == `PCU_BASE_BLK)
				|| ({word[9:4], 4'h0} == `PCU_BASE_NBLK))
			begin
				case (word[3:0])
					`PCU_IDX_CTL, `PCU_IDX_RST_STAT, `PCU_IDX_WAKE_STAT,
					`PCU_IDX_PRESC, `PCU_IDX_WUE_HI, `PCU_IDX_WUE_LO,
					`PCU_IDX_TRIM_HI, `PCU_IDX_TRIM_LO:
						pcu_decode = {1'b1, word[3:0]};
					default:
						pcu_decode = 5'h00;
				endcase
			end
		end
	endfunction

	// Input synchronisers
	reg  [SYNC_W-1:0] sync_a;
	reg  [SYNC_W-1:0] sync_b;
	reg  [EVT_W-1:0]  evt_prev;
	wire [SYNC_W-1:0] raw_in;
	wire [EVT_W-1:0]  evt_now;
	wire [EVT_W-1:0]  evt_rise;
	wire              ot_live;
	wire              uv_live;
	wire              crank_ok;
	wire [12:0]       trim_s;
	wire              trim_flag_s;

	assign raw_in = {overtemp_cond, undervolt_cond, crank_feature_en,
		trim_flag, trim_value, ms_tick, reset_cause_evt, wake_evt};
	assign ot_live     = sync_b[30];
	assign uv_live     = sync_b[29];
	assign crank_ok    = sync_b[28];
	assign trim_flag_s = sync_b[27];
	assign trim_s      = sync_b[26:14];
	assign evt_now     = sync_b[13:0];
	assign evt_rise    = evt_now & ~evt_prev;

	always @(posedge mclk)
	begin
		if (reset)
		begin
			sync_a   <= {SYNC_W{1'b0}};
			sync_b   <= {SYNC_W{1'b0}};
			evt_prev <= {EVT_W{1'b0}};
		end
		else
		begin
			sync_a   <= raw_in;
			sync_b   <= sync_a;
			evt_prev <= evt_now;
		end
	end

	// Bus slave state
	reg  [11:0] aw_addr;
	reg         aw_held;
	reg  [31:0] w_data;
	reg  [3:0]  w_strb;
	reg         w_held;
	wire        do_write;
	wire [4:0]  wr_dec;
	wire [4:0]  rd_dec;
	wire        wr_hit;
	wire [3:0]  wr_idx;
	wire        full16;
	wire        low8;

	assign s_axi_awready = ~aw_held;
	assign s_axi_wready  = ~w_held;
	assign s_axi_arready = ~s_axi_rvalid;
	assign do_write      = aw_held & w_held & ~s_axi_bvalid;
	assign wr_dec        = pcu_decode(aw_addr);
	assign rd_dec        = pcu_decode(s_axi_araddr);
	assign wr_hit        = do_write & wr_dec[4];
	assign wr_idx        = wr_dec[3:0];
	// Partial writes to 16-bit registers are dropped
	assign full16        = (w_strb[1:0] == 2'b11);
	assign low8          = w_strb[0];

	always @(posedge mclk)
	begin
		if (reset)
		begin
			aw_addr      <= 12'h000;
			aw_held      <= 1'b0;
			w_data       <= 32'h00000000;
			w_strb       <= 4'h0;
			w_held       <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `PCU_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && !aw_held)
			begin
				aw_addr <= s_axi_awaddr;
				aw_held <= 1'b1;
			end
			if (s_axi_wvalid && !w_held)
			begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				w_held <= 1'b1;
			end
			if (do_write)
			begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_dec[4] ? `PCU_RESP_OKAY
					: `PCU_RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Write decodes per register
	wire wr_ctl;
	wire wr_rst_stat;
	wire wr_wake_stat;
	wire wr_presc;
	wire wr_wue_hi;
	wire wr_wue_lo;
	wire rst_cmd;

	assign wr_ctl       = wr_hit && wr_idx == `PCU_IDX_CTL && full16;
	assign wr_rst_stat  = wr_hit && wr_idx == `PCU_IDX_RST_STAT && low8;
	assign wr_wake_stat = wr_hit && wr_idx == `PCU_IDX_WAKE_STAT && low8;
	assign wr_presc     = wr_hit && wr_idx == `PCU_IDX_PRESC && full16;
	assign wr_wue_hi    = wr_hit && wr_idx == `PCU_IDX_WUE_HI && low8;
	assign wr_wue_lo    = wr_hit && wr_idx == `PCU_IDX_WUE_LO && low8;
	// Reserved bits 12 and 4 are not decoded at all
	assign rst_cmd      = wr_ctl && w_data[`PCU_CTL_RST_MASK]
		&& w_data[`PCU_CTL_RST_CMD];

	// Command reset sequencer
	reg  [1:0] rst_state;
	reg  [8:0] rst_cnt;
	wire       die_rst;

	// Control logic stays cleared for the whole pulse
	assign die_rst = reset | rst_cmd | rst_state[1];

	always @(posedge mclk)
	begin
		if (reset)
		begin
			rst_state     <= ST_RUN;
			rst_cnt       <= 9'h000;
			die_reset_out <= 1'b0;
		end
		else
		begin
			case (rst_state)
				ST_RUN:
					if (rst_cmd)
					begin
						rst_state     <= ST_HOLD;
						rst_cnt       <= RST_PULSE_CYC[8:0] - 9'h001;
						die_reset_out <= 1'b1;
					end
				ST_HOLD:
					if (rst_cnt == 9'h000)
					begin
						rst_state     <= ST_RUN;
						die_reset_out <= 1'b0;
					end
					else
						rst_cnt <= rst_cnt - 9'h001;
				default:
				begin
					rst_state     <= ST_RUN;
					die_reset_out <= 1'b0;
				end
			endcase
		end
	end

	// Control fields
	reg [1:0] pf;
	reg [1:0] mode;
	reg       ot_ctl;
	reg       uv_ctl;

	always @(posedge mclk)
	begin
		if (die_rst)
		begin
			ot_ctl <= 1'b0;
			uv_ctl <= 1'b0;
			pf     <= 2'h0;
			mode   <= `PCU_MODE_NORMAL;
		end
		else if (wr_ctl)
		begin
			if (w_data[`PCU_CTL_OT_MASK])
				ot_ctl <= w_data[`PCU_CTL_OT_IRQ];
			if (w_data[`PCU_CTL_UV_MASK])
				uv_ctl <= w_data[`PCU_CTL_UV_IRQ];
			if (w_data[`PCU_CTL_PF_MASK_HI:`PCU_CTL_PF_MASK_LO] == 2'b11)
				pf <= w_data[`PCU_CTL_PF_HI:`PCU_CTL_PF_LO];
			if (w_data[`PCU_CTL_MD_MASK_HI:`PCU_CTL_MD_MASK_LO] == 2'b11)
				mode <= w_data[`PCU_CTL_MD_HI:`PCU_CTL_MD_LO];
		end
	end

	// Effective mode and interrupt enables
	always @(posedge mclk)
	begin
		if (reset)
		begin
			overtemp_irq_en  <= 1'b0;
			undervolt_irq_en <= 1'b0;
			mode_state       <= `PCU_MODE_NORMAL;
			cranking_active  <= 1'b0;
		end
		else
		begin
			overtemp_irq_en  <= ~ot_ctl;
			undervolt_irq_en <= ~uv_ctl;
			if (mode == `PCU_MODE_CRANK && !crank_ok)
				mode_state <= `PCU_MODE_STOP;
			else
				mode_state <= mode;
			cranking_active <= (mode == `PCU_MODE_CRANK) && crank_ok;
		end
	end

	// Divider value and wake enables
	always @(posedge mclk)
	begin
		if (die_rst)
		begin
			ms_divider_value <= PRESC_RESET;
			wake_enable      <= {1'b0, `PCU_WUE_RESET};
		end
		else
		begin
			if (wr_presc)
				ms_divider_value <= w_data[15:0];
			if (wr_wue_hi)
				wake_enable[7:0] <= w_data[7:0];
			if (wr_wue_lo)
				wake_enable[8] <= w_data[7];
		end
	end

	// Tick divider: 1, 2, 4 or 8 input ticks per output tick
	reg  [2:0] tick_cnt;
	wire [2:0] tick_top;
	wire       tick_in;

	assign tick_in  = evt_rise[13];
	assign tick_top = (3'h1 << pf) - 3'h1;

	always @(posedge mclk)
	begin
		if (die_rst)
		begin
			tick_cnt    <= 3'h0;
			scaled_tick <= 1'b0;
		end
		else
		begin
			scaled_tick <= 1'b0;
			if (tick_in)
			begin
				if (tick_cnt >= tick_top)
				begin
					tick_cnt    <= 3'h0;
					scaled_tick <= 1'b1;
				end
				else
					tick_cnt <= tick_cnt + 3'h1;
			end
		end
	end

	// Sticky status flags survive a command reset so the cause stays
	// visible; a set in the same cycle as a clear wins.
	reg  [5:0] rst_flags;
	reg  [7:0] wake_flags;
	wire [5:0] rst_set;
	wire [5:0] rst_clr;
	wire [7:0] wake_set;
	wire [7:0] wake_clr;

	// Bits: cmd reset, watchdog, high/low voltage, lifetime wake, lpm wake
	assign rst_set = {rst_cmd, evt_rise[12:10], evt_rise[9] & wake_enable[8],
		evt_rise[8]};
	assign rst_clr = wr_rst_stat ? w_data[5:0] : 6'h00;
	assign wake_clr = wr_wake_stat ? w_data[7:0] : 8'h00;

	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1)
		begin : g_wake
			assign wake_set[g] = evt_rise[g] & wake_enable[g];
		end
	endgenerate

	always @(posedge mclk)
	begin
		if (reset)
		begin
			rst_flags  <= 6'h00;
			wake_flags <= 8'h00;
		end
		else
		begin
			rst_flags  <= (rst_flags & ~rst_clr) | rst_set;
			wake_flags <= (wake_flags & ~wake_clr) | wake_set;
		end
	end

	// Live condition flags cannot clear; a 1 pulses the source clear
	always @(posedge mclk)
	begin
		if (reset)
		begin
			overtemp_irq_clr  <= 1'b0;
			undervolt_irq_clr <= 1'b0;
		end
		else
		begin
			overtemp_irq_clr  <= wr_rst_stat & w_data[7];
			undervolt_irq_clr <= wr_rst_stat & w_data[6];
		end
	end

	// Read path
	reg [31:0] rd_mux;

	always @*
	begin
		rd_mux = 32'h00000000;
		case (rd_dec[3:0])
			`PCU_IDX_CTL:
				rd_mux[7:0] = {ot_ctl, uv_ctl, 2'b00, pf, mode};
			`PCU_IDX_RST_STAT:
				rd_mux[7:0] = {ot_live, uv_live, rst_flags};
			`PCU_IDX_WAKE_STAT:
				rd_mux[7:0] = wake_flags;
			`PCU_IDX_PRESC:
				rd_mux[15:0] = ms_divider_value;
			`PCU_IDX_WUE_HI:
				rd_mux[7:0] = wake_enable[7:0];
			`PCU_IDX_WUE_LO:
				rd_mux[7:0] = {wake_enable[8], 7'h00};
			`PCU_IDX_TRIM_HI:
				rd_mux[7:0] = {trim_flag_s, 2'b00, trim_s[12:8]};
			`PCU_IDX_TRIM_LO:
				rd_mux[7:0] = trim_s[7:0];
			default:
				rd_mux = 32'h00000000;
		endcase
	end

	always @(posedge mclk)
	begin
		if (reset)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `PCU_RESP_OKAY;
		end
		else if (s_axi_arvalid && !s_axi_rvalid)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_dec[4] ? rd_mux : 32'h00000000;
			s_axi_rresp  <= rd_dec[4] ? `PCU_RESP_OKAY : `PCU_RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

endmodule

//--- dv/pcu_regs_chk.sv
// Assertion checker for the power, clock and reset register bank.
// Assumes it is bound onto pcu_regs; one clock, synchronous reset.
`timescale 1ns/1ns
`include "pcu_map.vh"
module pcu_regs_chk #(
	parameter RST_PULSE_CYC = 250
) (
	input wire        mclk,
	input wire        reset,
	input wire [11:0] s_axi_araddr,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0]  s_axi_rresp,
	input wire        s_axi_rvalid,
	input wire        s_axi_bvalid,
	input wire        overtemp_irq_en,
	input wire        undervolt_irq_en,
	input wire        overtemp_irq_clr,
	input wire        die_reset_out,
	input wire [1:0]  mode_state,
	input wire        cranking_active
);
	// Only one read in flight, so the held address matches rvalid
	reg  [11:0] ra;
	reg  [15:0] hi_cnt;
	wire        ctl_rd = s_axi_rvalid && ra[5:2] == 4'h0
	            && (ra[11:6] == 6'h20 || ra[11:6] == 6'h30);
	always @(posedge mclk)
	begin
		if (s_axi_arvalid && s_axi_arready)
			ra <= s_axi_araddr;
		hi_cnt <= die_reset_out ? hi_cnt + 16'h1 : 16'h0;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	AST_UNMAPPED: assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr[11:6] != 6'h20
		&& s_axi_araddr[11:6] != 6'h30 |=> s_axi_rvalid
		&& s_axi_rresp == `PCU_RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	AST_MASK_RD: assert property (
		ctl_rd |-> s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[5:4] == 2'h0)
		else $error("control mask or command bits read nonzero");
	AST_OT_POL: assert property (
		ctl_rd |-> s_axi_rdata[7] == !overtemp_irq_en)
		else $error("overtemp enable polarity wrong");
	AST_UV_POL: assert property (
		ctl_rd |-> s_axi_rdata[6] == !undervolt_irq_en)
		else $error("undervolt enable polarity wrong");
	AST_CRANK: assert property (
		cranking_active |-> mode_state == `PCU_MODE_CRANK)
		else $error("cranking without cranking mode");
	AST_MODE_WR: assert property (
		$changed(mode_state) && mode_state != 2'h3
		&& $past(mode_state) != 2'h3 |-> s_axi_bvalid || $past(s_axi_bvalid))
		else $error("mode moved without a write");
	AST_RST_PULSE: assert property (
		$fell(die_reset_out) |-> hi_cnt == RST_PULSE_CYC)
		else $error("die reset pulse length wrong");
	AST_CLR_PULSE: assert property (
		overtemp_irq_clr |=> !overtemp_irq_clr)
		else $error("interrupt clear longer than one cycle");
	AST_RESET_VAL: assert property (
		$fell(reset) |-> ##2 mode_state == `PCU_MODE_NORMAL
		&& overtemp_irq_en && undervolt_irq_en && !die_reset_out)
		else $error("control not at reset values");
endmodule

bind pcu_regs pcu_regs_chk #(.RST_PULSE_CYC(RST_PULSE_CYC)) u_chk (.*);

//--- dv/power_clock_reset_regs_test.sv
// Self-checking bench for the power, clock and reset register bank.
// Assumes pcu_regs with a 4-cycle die reset pulse; bench is bus master.
`timescale 1ns/1ns
`include "pcu_map.vh"
module power_clock_reset_regs_test;
	reg         mclk;
	reg         reset = 1'h1;
	reg         s_axi_awvalid = 1'h0;
	reg         s_axi_wvalid = 1'h0;
	reg         s_axi_arvalid = 1'h0;
	reg         overtemp_cond = 1'h0;
	reg         undervolt_cond = 1'h0;
	reg         crank_feature_en = 1'h0;
	reg         ms_tick = 1'h0;
	reg         trim_flag = 1'h0;
	reg  [11:0] s_axi_awaddr = 12'h0;
	reg  [11:0] s_axi_araddr = 12'h0;
	reg  [31:0] s_axi_wdata = 32'h0;
	reg  [3:0]  s_axi_wstrb = 4'h0;
	reg  [4:0]  reset_cause_evt = 5'h0;
	reg  [7:0]  wake_evt = 8'h0;
	reg  [12:0] trim_value = 13'h0;
	wire [2:0]  s_axi_awprot = 3'h0;
	wire [2:0]  s_axi_arprot = 3'h0;
	wire        s_axi_bready = 1'h1;
	wire        s_axi_rready = 1'h1;
	wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire        s_axi_rvalid, overtemp_irq_en, undervolt_irq_en;
	wire        overtemp_irq_clr, undervolt_irq_clr, die_reset_out;
	wire        cranking_active, scaled_tick;
	wire [1:0]  s_axi_bresp, s_axi_rresp, mode_state;
	wire [31:0] s_axi_rdata;
	wire [15:0] ms_divider_value;
	wire [8:0]  wake_enable;
	wire [31:0] irq_en = {30'h0, overtemp_irq_en, undervolt_irq_en};
	integer     errors = 0;
	integer     num_checks = 0;
	integer     st_cnt = 0;
	integer     clr_cnt = 0;
	integer     drst = 0;
	reg  [31:0] d;
	reg  [1:0]  r;

	pcu_regs #(.RST_PULSE_CYC(4)) u_dut (.*);

	initial
	begin
		mclk = 1'h0;
		forever #2 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		st_cnt <= st_cnt + scaled_tick;
		// Undervolt clears count in steps of 16 so both sources show
		clr_cnt <= clr_cnt + overtemp_irq_clr + {undervolt_irq_clr, 4'h0};
		drst <= drst + die_reset_out;
	end
	task summarize;
	begin
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
	endtask
	task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
	begin
		num_checks = num_checks + 1;
		if (g !== e)
		begin
			errors = errors + 1;
			$display("mismatch %0s exp %h got %h", nm, e, g);
		end
	end
	endtask
	task cyc(input integer n);
		repeat (n) @(posedge mclk);
	endtask
	// Address and data go out together; each is dropped once taken
	// Only the watchdog ends a wait for the response
	task wr(input [11:0] a, input [31:0] v, input [3:0] s, input [1:0] e);
	begin
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do
		begin
			@(posedge mclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		chk("bresp", {30'h0, e}, {30'h0, s_axi_bresp});
	end
	endtask
	task w(input [11:0] a, input [31:0] v);
		wr(a, v, 4'hF, `PCU_RESP_OKAY);
	endtask
	task rd(input [11:0] a);
	begin
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do
		begin
			@(posedge mclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
	end
	endtask
	task rc(input [11:0] a, input [31:0] e);
	begin
		rd(a);
		chk("rresp", 32'h0, {30'h0, r});
		chk("rdata", e, d);
	end
	endtask
	// Ticks pass two sync flops, so each is followed by settling time
	task ticks(output integer n);
		integer k;
	begin
		k = st_cnt;
		n = 0;
		while (st_cnt == k && n < 20)
		begin
			ms_tick <= 1'h1;
			cyc(1);
			ms_tick <= 1'h0;
			cyc(6);
			n = n + 1;
		end
	end
	endtask
	task t_mask;
	begin
		rc(12'h810, {16'h0, `PCU_PRESC_RESET});
		chk("irq_en", 32'h3, irq_en);
		w(12'h800, 32'h00C0);
		rc(12'h800, 32'h0);
		w(12'h800, 32'h80C0);
		rc(12'h800, 32'h80);
		chk("irq_en", 32'h1, irq_en);
		w(12'h800, 32'h4040);
		rc(12'h800, 32'hC0);
		chk("irq_en", 32'h0, irq_en);
		w(12'h800, 32'hC000);
		cyc(2);
		chk("irq_en", 32'h3, irq_en);
	end
	endtask
	task t_mode;
		integer m;
	begin
		w(12'h800, 32'h080C);
		w(12'h800, 32'h040C);
		rc(12'h800, 32'h0);
		for (m = 0; m < 3; m = m + 1)
		begin
			w(12'h800, 32'h0300 + m);
			w(12'h800, 32'h0203);
			cyc(2);
			chk("mode", m, {30'h0, mode_state});
		end
		w(12'h800, 32'h0303);
		cyc(8);
		chk("mode", 32'h1, {30'h0, mode_state});
		rc(12'h800, 32'h3);
		crank_feature_en <= 1'h1;
		cyc(8);
		chk("mode", 32'h3, {30'h0, mode_state});
		chk("crank", 32'h1, {31'h0, cranking_active});
		w(12'h800, 32'h0300);
		crank_feature_en <= 1'h0;
	end
	endtask
	task t_tick;
		integer p, n;
	begin
		for (p = 0; p < 4; p = p + 1)
		begin
			w(12'h800, 32'h0C00 + 4 * p);
			ticks(n);
			ticks(n);
			chk("div", 1 << p, n);
		end
	end
	endtask
	task t_status;
	begin
		wr(12'h818, 32'hA5, 4'h1, `PCU_RESP_OKAY);
		wr(12'h81C, 32'hFF, 4'h1, `PCU_RESP_OKAY);
		rc(12'h818, 32'hA5);
		rc(12'h81C, 32'h80);
		chk("wue", 32'h1A5, {23'h0, wake_enable});
		wake_evt <= 8'hC0;
		cyc(1);
		wake_evt <= 8'h00;
		cyc(6);
		rc(12'h80C, 32'h80);
		w(12'h80C, 32'h7F);
		rc(12'h80C, 32'h80);
		w(12'h80C, 32'h80);
		rc(12'h80C, 32'h0);
		reset_cause_evt <= 5'h10;
		cyc(1);
		reset_cause_evt <= 5'h0;
		cyc(6);
		rc(12'h808, 32'h10);
		w(12'h808, 32'h10);
		rc(12'h808, 32'h0);
	end
	endtask
	task t_live;
		integer k;
	begin
		overtemp_cond <= 1'h1;
		undervolt_cond <= 1'h1;
		cyc(6);
		rc(12'h808, 32'hC0);
		k = clr_cnt;
		w(12'h808, 32'hC0);
		cyc(3);
		rc(12'h808, 32'hC0);
		chk("clr", k + 17, clr_cnt);
		overtemp_cond <= 1'h0;
		undervolt_cond <= 1'h0;
		cyc(6);
		rc(12'h808, 32'h0);
	end
	endtask
	task t_bus;
	begin
		w(12'hC10, 32'h1234);
		rc(12'h810, 32'h1234);
		chk("divider", 32'h1234, {16'h0, ms_divider_value});
		wr(12'h810, 32'h5555, 4'h1, `PCU_RESP_OKAY);
		rc(12'h810, 32'h1234);
		rd(12'h814);
		chk("rresp", 32'h2, {30'h0, r});
		chk("rdata", 32'h0, d);
		wr(12'h7FC, 32'h1, 4'hF, `PCU_RESP_SLVERR);
		rd(12'h400);
		chk("rresp", 32'h2, {30'h0, r});
		chk("rdata", 32'h0, d);
		trim_value <= 13'h1ABC;
		trim_flag <= 1'h1;
		cyc(4);
		rc(12'h83C, 32'hBC);
		rc(12'hC38, 32'h9A);
	end
	endtask
	task t_cmd;
		integer k;
	begin
		w(12'h800, 32'h0C0C);
		k = drst;
		w(12'h800, 32'h2000);
		w(12'h800, 32'h0020);
		cyc(8);
		chk("die_rst", k, drst);
		rc(12'h800, 32'h0C);
		w(12'h800, 32'h2020);
		cyc(12);
		chk("die_rst", k + 4, drst);
		rc(12'h800, 32'h0);
		rc(12'h810, {16'h0, `PCU_PRESC_RESET});
		rc(12'h808, 32'h20);
		w(12'h808, 32'h20);
		rc(12'h808, 32'h0);
	end
	endtask
	initial
	begin
		repeat (6) @(posedge mclk);
		reset <= 1'h0;
		cyc(3);
		t_mask;
		t_mode;
		t_tick;
		t_status;
		t_live;
		t_bus;
		t_cmd;
		summarize;
	end
	// Whole run is a few hundred cycles; this only catches a hang
	initial
	begin
		#100000;
		errors = errors + 1;
		summarize;
	end
endmodule
